// ===== rsm_pkg.sv
package rsm_pkg;
	localparam int NUM_CH    = 2;
	localparam int DATA_W    = 512;
	localparam int CNT_W     = 16;
	localparam int LEN_W     = 48;
	localparam int BEAT_BYTES   = DATA_W / 8;
	localparam int STRIPE_BYTES = 512;
	localparam int FREE_BYTES   = 1024;
	// Thresholds in 64-byte beats
	localparam logic [CNT_W-1:0] STRIPE_BEATS = CNT_W'(STRIPE_BYTES / BEAT_BYTES);
	localparam logic [CNT_W-1:0] MIN_FREE     = CNT_W'(FREE_BYTES / BEAT_BYTES);
	localparam logic [CNT_W-1:0] TWO_STRIPES  = CNT_W'(2 * STRIPE_BYTES / BEAT_BYTES);
	localparam logic [2:0] LAST_BEAT     = 3'h7;
	localparam logic [1:0] SETTLE_LAST   = 2'h2;
	localparam int         SEL_DELAY     = 2;
	localparam logic [CNT_W-1:0] HOST_RX_DEPTH_DEF = 16'h0400;
	localparam logic [LEN_W-1:0] LEN_RST = 48'h0;
	localparam logic             SEL_RST = 1'h0;

	typedef enum logic [2:0] {
		IDLE_ST,
		WAIT_READY_ST,
		MOVE_STRIPE_ST,
		SETTLE_ST,
		DRAIN_END_ST
	} rsm_state_t;
endpackage

// ===== rsm_sel_if.sv
`timescale 1ns/1ps
interface rsm_sel_if #(parameter int W = 16);
	logic         sel;
	logic [W-1:0] count;
	modport ctl (output sel, input count);
	modport mux (input sel, output count);
endinterface

// ===== rsm_chan_mux.sv
`timescale 1ns/1ps
module rsm_chan_mux #(
	parameter int N = 2,
	parameter int W = 16
) (
	input  wire logic                 mclk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic [N-1:0][W-1:0]  count_i,
	rsm_sel_if.mux                    sif
);
	logic [W-1:0] picked;
	logic [W-1:0] count_r;

	assign picked    = count_i[sif.sel];
	assign sif.count = count_r;

	// Registered pick: one clock later than the channel counts
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			count_r <= '0;
		end else begin
			count_r <= picked;
		end
	end
endmodule // rsm_chan_mux

// ===== rsm_delay.sv
`timescale 1ns/1ps
module rsm_delay #(
	parameter int W     = 3,
	parameter int DEPTH = 2
) (
	input  wire logic                     mclk_i,
	input  wire logic                     sys_rst_i,
	input  wire logic [W-1:0]             in_i,
	output logic      [DEPTH-1:0][W-1:0]  tap_o
);
	logic [DEPTH-1:0][W-1:0] tap_r;

	assign tap_o = tap_r;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			tap_r <= '0;
		end else begin
			tap_r <= {tap_r[DEPTH-2:0], in_i};
		end
	end
endmodule // rsm_delay

// ===== rsm_mover.sv
`timescale 1ns/1ps
module rsm_mover #(
	parameter logic [15:0] HOST_RX_DEPTH = rsm_pkg::HOST_RX_DEPTH_DEF
) (
	input  wire logic                                       mclk_i,
	input  wire logic                                       sys_rst_i,
	// Operation request
	input  wire logic                                       op_start_i,
	input  wire logic                                       op_write_i,
	input  wire logic [rsm_pkg::LEN_W-1:0]                  op_len_i,
	output logic                                            busy_o,
	output logic                                            done_o,
	// Host transmit queue
	input  wire logic [rsm_pkg::CNT_W-1:0]                  host_tx_fill_count_i,
	output logic                                            host_tx_read_enable_o,
	input  wire logic [rsm_pkg::DATA_W-1:0]                 host_tx_read_data_i,
	// Host receive queue
	input  wire logic [rsm_pkg::CNT_W-1:0]                  host_rx_write_count_i,
	output logic                                            host_rx_write_enable_o,
	output logic      [rsm_pkg::DATA_W-1:0]                 host_rx_write_data_o,
	// Channel transmit queues
	input  wire logic [rsm_pkg::NUM_CH-1:0][rsm_pkg::CNT_W-1:0]  chan_tx_free_count_i,
	output logic      [rsm_pkg::NUM_CH-1:0]                 chan_tx_write_enable_o,
	output logic      [rsm_pkg::DATA_W-1:0]                 chan_tx_write_data_o,
	// Channel receive queues
	input  wire logic [rsm_pkg::NUM_CH-1:0][rsm_pkg::CNT_W-1:0]  chan_rx_fill_count_i,
	output logic      [rsm_pkg::NUM_CH-1:0]                 chan_rx_read_enable_o,
	input  wire logic [rsm_pkg::NUM_CH-1:0][rsm_pkg::DATA_W-1:0] chan_rx_read_data_i,
	// Channel controllers
	input  wire logic [rsm_pkg::NUM_CH-1:0]                 chan_busy_i
);
	rsm_pkg::rsm_state_t state_r;
	rsm_pkg::rsm_state_t state_nxt;

	logic                       write_mode_r;
	logic [rsm_pkg::LEN_W-1:0]  remain_r;
	logic [rsm_pkg::LEN_W-1:0]  remain_nxt;
	logic [2:0]                 beat_r;
	logic [1:0]                 settle_r;
	logic                       active_channel_sel_r;
	logic                       active_channel_sel_nxt;
	logic                       next_channel_sel_r;
	logic                       next_channel_sel_nxt;
	logic                       done_r;
	logic [rsm_pkg::DATA_W-1:0] data_r;

	// Decoded conditions
	logic                       in_idle;
	logic                       in_wait;
	logic                       in_move;
	logic                       in_settle;
	logic                       in_drain;
	logic                       last_beat;
	logic                       settle_done;
	logic                       remain_zero;
	logic                       remain_one;
	logic                       move_wr;
	logic                       move_rd;
	logic                       host_tx_has_stripe;
	logic                       host_tx_has_two;
	logic                       host_rx_has_room;
	logic                       chan_tx_has_room;
	logic                       chan_rx_has_stripe;
	logic                       wr_ready;
	logic                       rd_ready;
	logic                       start_stripe;
	logic                       pipe_idle;
	logic                       chans_idle;
	logic [rsm_pkg::CNT_W:0]    rx_used_plus_free;

	// Delay taps: {write beat, read beat, channel}
	logic [2:0]                 pipe_in;
	logic [1:0][2:0]            tap;
	logic                       tap1_wr;
	logic                       tap1_rd;
	logic                       tap1_sel;
	logic                       tap2_wr;
	logic                       tap2_rd;
	logic                       tap2_sel;

	rsm_sel_if #(.W(rsm_pkg::CNT_W)) tx_sif ();
	rsm_sel_if #(.W(rsm_pkg::CNT_W)) rx_sif ();

	// Both count muxes look at the channel that will be active next
	assign tx_sif.sel = next_channel_sel_r;
	assign rx_sif.sel = next_channel_sel_r;

	rsm_chan_mux #(
		.N (rsm_pkg::NUM_CH),
		.W (rsm_pkg::CNT_W)
	) u_tx_free_mux (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.count_i   (chan_tx_free_count_i),
		.sif       (tx_sif)
	);

	rsm_chan_mux #(
		.N (rsm_pkg::NUM_CH),
		.W (rsm_pkg::CNT_W)
	) u_rx_fill_mux (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.count_i   (chan_rx_fill_count_i),
		.sif       (rx_sif)
	);

	rsm_delay #(
		.W     (3),
		.DEPTH (rsm_pkg::SEL_DELAY)
	) u_sel_delay (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.in_i      (pipe_in),
		.tap_o     (tap)
	);

	assign in_idle   = (state_r == rsm_pkg::IDLE_ST);
	assign in_wait   = (state_r == rsm_pkg::WAIT_READY_ST);
	assign in_move   = (state_r == rsm_pkg::MOVE_STRIPE_ST);
	assign in_settle = (state_r == rsm_pkg::SETTLE_ST);
	assign in_drain  = (state_r == rsm_pkg::DRAIN_END_ST);

	assign last_beat   = in_move && (beat_r == rsm_pkg::LAST_BEAT);
	assign settle_done = in_settle && (settle_r == rsm_pkg::SETTLE_LAST);
	assign remain_zero = (remain_r == '0);
	assign remain_one  = (remain_r == rsm_pkg::LEN_W'(1));
	assign move_wr     = in_move && write_mode_r;
	assign move_rd     = in_move && !write_mode_r;

	// Queue level checks, in 64-byte beats
	assign host_tx_has_stripe = (host_tx_fill_count_i >= rsm_pkg::STRIPE_BEATS);
	assign host_tx_has_two    = (host_tx_fill_count_i >= rsm_pkg::TWO_STRIPES);
	assign chan_tx_has_room   = (tx_sif.count >= rsm_pkg::MIN_FREE);
	assign chan_rx_has_stripe = (rx_sif.count >= rsm_pkg::STRIPE_BEATS);
	// Free room = depth - used; an oversized used count reads as full
	assign rx_used_plus_free  = {1'b0, host_rx_write_count_i} + {1'b0, rsm_pkg::MIN_FREE};
	assign host_rx_has_room   = (rx_used_plus_free <= {1'b0, HOST_RX_DEPTH});

	assign wr_ready = host_tx_has_stripe && chan_tx_has_room;
	assign rd_ready = chan_rx_has_stripe && host_rx_has_room;

	assign start_stripe = in_wait && !remain_zero
			&& (write_mode_r ? wr_ready : rd_ready);

	assign pipe_in  = {move_wr, move_rd, active_channel_sel_r};
	assign tap1_wr  = tap[0][2];
	assign tap1_rd  = tap[0][1];
	assign tap1_sel = tap[0][0];
	assign tap2_wr  = tap[1][2];
	assign tap2_rd  = tap[1][1];
	assign tap2_sel = tap[1][0];

	assign pipe_idle  = !(tap1_wr || tap1_rd || tap2_wr || tap2_rd);
	assign chans_idle = (chan_busy_i == '0);

	// Handshake, data and status outputs
	assign host_tx_read_enable_o = move_wr;
	assign chan_rx_read_enable_o = move_rd
			? rsm_pkg::NUM_CH'(1) << active_channel_sel_r
			: '0;
	assign chan_tx_write_enable_o = tap2_wr
			? rsm_pkg::NUM_CH'(1) << tap2_sel
			: '0;
	assign host_rx_write_enable_o = tap2_rd;
	assign chan_tx_write_data_o   = data_r;
	assign host_rx_write_data_o   = data_r;
	assign busy_o                 = !in_idle;
	assign done_o                 = done_r;

	// Next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			rsm_pkg::IDLE_ST: begin
				if (op_start_i) begin
					state_nxt = rsm_pkg::WAIT_READY_ST;
				end
			end
			rsm_pkg::WAIT_READY_ST: begin
				if (remain_zero && write_mode_r && pipe_idle) begin
					state_nxt = rsm_pkg::IDLE_ST;
				end else if (remain_zero && !write_mode_r) begin
					state_nxt = rsm_pkg::DRAIN_END_ST;
				end else if (start_stripe) begin
					state_nxt = rsm_pkg::MOVE_STRIPE_ST;
				end
			end
			rsm_pkg::MOVE_STRIPE_ST: begin
				if (last_beat && write_mode_r) begin
					if (host_tx_has_two) begin
						state_nxt = rsm_pkg::WAIT_READY_ST;
					end else begin
						state_nxt = rsm_pkg::SETTLE_ST;
					end
				end else if (last_beat) begin
					if (remain_one) begin
						state_nxt = rsm_pkg::DRAIN_END_ST;
					end else begin
						state_nxt = rsm_pkg::WAIT_READY_ST;
					end
				end
			end
			rsm_pkg::SETTLE_ST: begin
				if (settle_done) begin
					state_nxt = rsm_pkg::WAIT_READY_ST;
				end
			end
			rsm_pkg::DRAIN_END_ST: begin
				if (chans_idle && pipe_idle) begin
					state_nxt = rsm_pkg::IDLE_ST;
				end
			end
			default: begin
				state_nxt = rsm_pkg::IDLE_ST;
			end
		endcase
	end

	// Length and channel selectors
	always_comb begin
		remain_nxt             = remain_r;
		active_channel_sel_nxt = active_channel_sel_r;
		next_channel_sel_nxt   = next_channel_sel_r;
		if (in_idle && op_start_i) begin
			remain_nxt             = op_len_i;
			active_channel_sel_nxt = rsm_pkg::SEL_RST;
			next_channel_sel_nxt   = rsm_pkg::SEL_RST;
		end else if (in_move) begin
			// One-bit add wraps channel 1 back to 0
			next_channel_sel_nxt = active_channel_sel_r + 1'b1;
			if (last_beat) begin
				active_channel_sel_nxt = active_channel_sel_r + 1'b1;
				remain_nxt             = remain_r - rsm_pkg::LEN_W'(1);
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state_r <= rsm_pkg::IDLE_ST;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			remain_r             <= rsm_pkg::LEN_RST;
			active_channel_sel_r <= rsm_pkg::SEL_RST;
			next_channel_sel_r   <= rsm_pkg::SEL_RST;
		end else begin
			remain_r             <= remain_nxt;
			active_channel_sel_r <= active_channel_sel_nxt;
			next_channel_sel_r   <= next_channel_sel_nxt;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			write_mode_r <= 1'b0;
		end else if (in_idle && op_start_i) begin
			write_mode_r <= op_write_i;
		end
	end

	// Beat counter within a stripe
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			beat_r <= '0;
		end else if (in_move) begin
			beat_r <= beat_r + 3'h1;
		end else begin
			beat_r <= '0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			settle_r <= '0;
		end else if (in_settle) begin
			settle_r <= settle_r + 2'h1;
		end else begin
			settle_r <= '0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			done_r <= 1'b0;
		end else begin
			done_r <= !in_idle && (state_nxt == rsm_pkg::IDLE_ST);
		end
	end

	// Data stage: source data is valid one clock after its read enable
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			data_r <= '0;
		end else if (tap1_wr) begin
			data_r <= host_tx_read_data_i;
		end else if (tap1_rd) begin
			data_r <= chan_rx_read_data_i[tap1_sel];
		end
	end
endmodule // rsm_mover

// ===== rsm_mover_properties.sv
`timescale 1ns/1ps
module rsm_mover_props #(
	parameter logic [15:0] HOST_RX_DEPTH = rsm_pkg::HOST_RX_DEPTH_DEF
) (
	input wire logic             mclk_i,
	input wire logic             sys_rst_i,
	input wire logic             op_start_i,
	input wire logic             op_write_i,
	input wire logic             busy_o,
	input wire logic             done_o,
	input wire logic [15:0]      host_tx_fill_count_i,
	input wire logic             host_tx_read_enable_o,
	input wire logic [511:0]     host_tx_read_data_i,
	input wire logic [15:0]      host_rx_write_count_i,
	input wire logic             host_rx_write_enable_o,
	input wire logic [511:0]     host_rx_write_data_o,
	input wire logic [1:0]       chan_tx_write_enable_o,
	input wire logic [511:0]     chan_tx_write_data_o,
	input wire logic [1:0]       chan_rx_read_enable_o,
	input wire logic [1:0][511:0] chan_rx_read_data_i,
	input wire logic [1:0]       chan_busy_i
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);
	logic rd_op_r;
	logic seen_r;
	logic last_r;
	// Remembers the kind of operation and the channel of the last write beat
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rd_op_r <= 1'b0;
			seen_r  <= 1'b0;
			last_r  <= 1'b0;
		end else begin
			if (op_start_i && !busy_o)
				rd_op_r <= !op_write_i;
			if (|chan_tx_write_enable_o) begin
				seen_r <= 1'b1;
				last_r <= chan_tx_write_enable_o[1];
			end
		end
	end
	a_wr_stripe_len: assert property ($rose(host_tx_read_enable_o)
		|-> host_tx_read_enable_o[*8] ##1 !host_tx_read_enable_o) else $error("tx read length");
	a_rd_stripe_len: assert property ($rose(|chan_rx_read_enable_o)
		|-> $onehot(chan_rx_read_enable_o)[*8] ##1 chan_rx_read_enable_o == 2'h0)
		else $error("rx read length");
	a_tx_write_lag: assert property (host_tx_read_enable_o
		|-> ##2 $onehot(chan_tx_write_enable_o)) else $error("tx write lag");
	a_tx_data_fwd: assert property (|chan_tx_write_enable_o
		|-> chan_tx_write_data_o == $past(host_tx_read_data_i)) else $error("tx data");
	a_rx_data_fwd: assert property (host_rx_write_enable_o |-> host_rx_write_data_o ==
		($past(chan_rx_read_enable_o[1], 2) ? $past(chan_rx_read_data_i[1])
		: $past(chan_rx_read_data_i[0]))) else $error("rx data");
	a_chan_alternate: assert property ($rose(|chan_tx_write_enable_o) && seen_r
		|-> chan_tx_write_enable_o[1] != last_r) else $error("channel not rotated");
	a_tx_fill_gate: assert property ($rose(host_tx_read_enable_o)
		|-> $past(host_tx_fill_count_i) >= rsm_pkg::STRIPE_BEATS) else $error("tx gate");
	a_rx_free_gate: assert property ($rose(|chan_rx_read_enable_o)
		|-> HOST_RX_DEPTH - $past(host_rx_write_count_i) >= rsm_pkg::MIN_FREE)
		else $error("rx gate");
	a_settle_gap: assert property ($fell(host_tx_read_enable_o)
		&& $past(host_tx_fill_count_i) < rsm_pkg::TWO_STRIPES
		|-> !host_tx_read_enable_o[*4]) else $error("settle too short");
	// The end-wait state sees busy low in the cycle before the pulse
	a_end_busy: assert property (rd_op_r && done_o |->
		$past(chan_busy_i) == 2'h0) else $error("end early");
	c_settle: cover property ($fell(host_tx_read_enable_o) && host_tx_fill_count_i < 16'h8);
	c_rd_done: cover property (rd_op_r && done_o);
	c_wr_done: cover property (!rd_op_r && done_o);
endmodule // rsm_mover_props

bind rsm_mover rsm_mover_props #(.HOST_RX_DEPTH(HOST_RX_DEPTH)) i_rsm_mover_props (
	.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .op_start_i(op_start_i),
	.op_write_i(op_write_i), .busy_o(busy_o), .done_o(done_o),
	.host_tx_fill_count_i(host_tx_fill_count_i), .host_tx_read_enable_o(host_tx_read_enable_o),
	.host_tx_read_data_i(host_tx_read_data_i), .host_rx_write_count_i(host_rx_write_count_i),
	.host_rx_write_enable_o(host_rx_write_enable_o), .host_rx_write_data_o(host_rx_write_data_o),
	.chan_tx_write_enable_o(chan_tx_write_enable_o), .chan_tx_write_data_o(chan_tx_write_data_o),
	.chan_rx_read_enable_o(chan_rx_read_enable_o), .chan_rx_read_data_i(chan_rx_read_data_i),
	.chan_busy_i(chan_busy_i));

// ===== rsm_queue_model.sv
`timescale 1ns/1ps
module rsm_queue_model (
	input  wire logic              mclk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              stall_i,
	input  wire logic              tx_add_i,
	input  wire logic [1:0]        rx_add_i,
	input  wire logic              host_tx_read_enable_i,
	input  wire logic              host_rx_write_enable_i,
	input  wire logic [1:0]        chan_tx_write_enable_i,
	input  wire logic [1:0]        chan_rx_read_enable_i,
	output logic      [15:0]       host_tx_fill_count_o,
	output logic      [511:0]      host_tx_read_data_o,
	output logic      [15:0]       host_rx_write_count_o,
	output logic      [1:0][15:0]  chan_tx_free_count_o,
	output logic      [1:0][15:0]  chan_rx_fill_count_o,
	output logic      [1:0][511:0] chan_rx_read_data_o
);
	logic [31:0]      tx_seq_r;
	logic [1:0][30:0] rx_seq_r;
	logic [1:0][15:0] tx_used_r;
	assign chan_tx_free_count_o[0] = 16'h0020 - tx_used_r[0];
	assign chan_tx_free_count_o[1] = 16'h0020 - tx_used_r[1];
	// Stored data is valid the cycle after a read enable, otherwise it keeps changing
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			{tx_seq_r, rx_seq_r, tx_used_r, host_tx_fill_count_o} <= '0;
			{host_tx_read_data_o, host_rx_write_count_o} <= '0;
			{chan_rx_fill_count_o, chan_rx_read_data_o} <= '0;
		end else begin
			host_tx_read_data_o <= host_tx_read_enable_i ? {16{tx_seq_r}}
				: ~host_tx_read_data_o;
			tx_seq_r <= tx_seq_r + 32'(host_tx_read_enable_i);
			host_tx_fill_count_o <= host_tx_fill_count_o + (tx_add_i ? 16'h8 : 16'h0)
				- 16'(host_tx_read_enable_i);
			host_rx_write_count_o <= host_rx_write_count_o + 16'(host_rx_write_enable_i)
				- 16'(!stall_i && host_rx_write_count_o != 16'h0);
			for (int c = 0; c < 2; c++) begin
				chan_rx_read_data_o[c] <= chan_rx_read_enable_i[c]
					? {16{1'(c), rx_seq_r[c]}} : ~chan_rx_read_data_o[c];
				rx_seq_r[c] <= rx_seq_r[c] + 31'(chan_rx_read_enable_i[c]);
				chan_rx_fill_count_o[c] <= chan_rx_fill_count_o[c]
					+ (rx_add_i[c] ? 16'h8 : 16'h0) - 16'(chan_rx_read_enable_i[c]);
				tx_used_r[c] <= tx_used_r[c] + 16'(chan_tx_write_enable_i[c])
					- 16'(!stall_i && tx_used_r[c] != 16'h0);
			end
		end
	end
endmodule // rsm_queue_model

// ===== rsm_mover_tb.sv
`timescale 1ns/1ps
module rsm_mover_tb;
	logic                mclk = 1'b0;
	logic                rst, op_start, op_write, busy, done, tx_re, rx_we, stall, tx_add;
	logic [47:0]         op_len;
	logic [15:0]         tx_fill, rx_cnt;
	logic [511:0]        tx_data, rx_wdata, ctx_wdata;
	logic [1:0]          ctx_we, crx_re, rx_add, chan_busy;
	logic [1:0][15:0]    ctx_free, crx_fill;
	logic [1:0][511:0]   crx_data;
	int                  mismatches = 0, total_checks = 0, seed = 90;
	int                  tx_n, rx_n, done_n, len;

	always #20 mclk = ~mclk;

	rsm_mover #(.HOST_RX_DEPTH(16'h0020)) i_rsm_mover (.mclk_i(mclk), .sys_rst_i(rst),
		.op_start_i(op_start), .op_write_i(op_write), .op_len_i(op_len), .busy_o(busy),
		.done_o(done), .host_tx_fill_count_i(tx_fill), .host_tx_read_enable_o(tx_re),
		.host_tx_read_data_i(tx_data), .host_rx_write_count_i(rx_cnt),
		.host_rx_write_enable_o(rx_we), .host_rx_write_data_o(rx_wdata),
		.chan_tx_free_count_i(ctx_free), .chan_tx_write_enable_o(ctx_we),
		.chan_tx_write_data_o(ctx_wdata), .chan_rx_fill_count_i(crx_fill),
		.chan_rx_read_enable_o(crx_re), .chan_rx_read_data_i(crx_data), .chan_busy_i(chan_busy));
	rsm_queue_model i_rsm_queue_model (.mclk_i(mclk), .sys_rst_i(rst), .stall_i(stall),
		.tx_add_i(tx_add), .rx_add_i(rx_add), .host_tx_read_enable_i(tx_re),
		.host_rx_write_enable_i(rx_we), .chan_tx_write_enable_i(ctx_we),
		.chan_rx_read_enable_i(crx_re), .host_tx_fill_count_o(tx_fill),
		.host_tx_read_data_o(tx_data), .host_rx_write_count_o(rx_cnt),
		.chan_tx_free_count_o(ctx_free), .chan_rx_fill_count_o(crx_fill),
		.chan_rx_read_data_o(crx_data));

	function automatic logic [511:0] exp_rx(input int n);
		return {16{1'((n / 8) % 2), 31'((n / 16) * 8 + n % 8)}};
	endfunction
	task automatic check(input string nm, input logic [511:0] seen, input logic [511:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic reset_dut();
		rst = 1'b1;
		repeat (6) @(negedge mclk);
		rst = 1'b0;
		{tx_n, rx_n, done_n} = '0;
		@(negedge mclk);
	endtask
	task automatic start(input logic wr, input logic [47:0] n);
		{op_write, op_len, op_start} = {wr, n, 1'b1};
		@(negedge mclk);
		op_start = 1'b0;
		check("busy", 512'(busy), 512'h1);
	endtask
	task automatic feed(input logic tx, input logic [1:0] rx, input int n);
		{tx_add, rx_add} = {tx, rx};
		repeat (n) @(negedge mclk);
		{tx_add, rx_add} = '0;
	endtask
	task automatic wait_done(input int lim);
		for (int k = 0; k < lim && done_n == 0; k++)
			@(negedge mclk);
		check("done_count", 512'(done_n), 512'h1);
	endtask

	// Random stall of the drain side of both queues
	always @(negedge mclk)
		stall <= ($random(seed) & 3) == 0;
	always @(negedge mclk) begin
		if (!rst) begin
			if (|ctx_we) begin
				check("tx_chan", 512'(ctx_we), 512'(2'h1 << ((tx_n / 8) % 2)));
				check("tx_data", ctx_wdata, {16{32'(tx_n)}});
				tx_n++;
			end
			if (rx_we) begin
				check("rx_data", rx_wdata, exp_rx(rx_n));
				rx_n++;
			end
			done_n += int'(done === 1'b1);
		end
	end
	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		wrap_up();
	end
	initial begin
		{rst, op_start, op_write, tx_add, op_len, rx_add, chan_busy} = '0;
		len = 3 + ($random(seed) & 3);
		reset_dut();
		start(1'b1, 48'(len));
		feed(1'b1, 2'h0, len);
		start(1'b1, 48'h1);
		wait_done(600);
		check("tx_beats", 512'(tx_n), 512'(8 * len));
		// Host data trickles in: the second stripe must wait and pass the settle state
		reset_dut();
		start(1'b1, 48'h2);
		feed(1'b1, 2'h0, 1);
		repeat (40) @(negedge mclk);
		check("tx_starved", 512'(tx_n), 512'h8);
		feed(1'b1, 2'h0, 1);
		wait_done(200);
		reset_dut();
		start(1'b1, 48'h0);
		wait_done(30);
		check("tx_zero", 512'(tx_n), 512'h0);
		// Read of four stripes, the last channel starved, busy held past the data
		reset_dut();
		chan_busy = 2'h3;
		feed(1'b0, 2'h3, 1);
		feed(1'b0, 2'h1, 1);
		start(1'b0, 48'h4);
		repeat (150) @(negedge mclk);
		check("rx_starved", 512'(rx_n), 512'd24);
		feed(1'b0, 2'h2, 1);
		repeat (100) @(negedge mclk);
		check("early_done", 512'(done_n), 512'h0);
		chan_busy = 2'h0;
		wait_done(40);
		check("rx_beats", 512'(rx_n), 512'd32);
		// Reset in mid-write clears every handshake and status output
		reset_dut();
		feed(1'b1, 2'h0, 2);
		start(1'b1, 48'h4);
		repeat (5) @(negedge mclk);
		rst = 1'b1;
		@(negedge mclk);
		check("rst_outs", 512'({busy, done, tx_re, rx_we, ctx_we, crx_re}), 512'h0);
		wrap_up();
	end
endmodule // rsm_mover_tb
